// file: logic/hpg_pkg.sv
// Package for the high-port GPIO block: register offsets, reset values,
// field positions and the nibble expansion used by the drive logic.
// Assumes an 8-bit special-function-register bus with byte offsets.
`default_nettype none
package hpg_pkg;
    // Register offsets on the special-function-register bus.
    localparam logic [7:0] HPG_P3_DATA_ADDR  = 8'hB0;
    localparam logic [7:0] HPG_P3_DRIVE_ADDR = 8'hA7;
    localparam logic [7:0] HPG_P3_FLAGS_ADDR = 8'hAD;
    localparam logic [7:0] HPG_HP_DRIVE_ADDR = 8'hB5;
    localparam logic [7:0] HPG_P4_DATA_ADDR  = 8'h84;
    localparam logic [7:0] HPG_P5_DATA_ADDR  = 8'h85;
    localparam logic [7:0] HPG_P6_DATA_ADDR  = 8'h86;
    localparam logic [7:0] HPG_P7_DATA_ADDR  = 8'h96;
    // Reset values.
    localparam logic [7:0] HPG_LATCH_RST = 8'hFF;
    localparam logic [7:0] HPG_DRIVE_RST = 8'h00;
    localparam logic [7:0] HPG_FLAGS_RST = 8'h00;
    // Field positions in the port 3 edge flag register.
    localparam int HPG_IRQ7_BIT = 7;
    localparam int HPG_IRQ6_BIT = 6;
    localparam int HPG_CF7_BIT  = 3;
    localparam int HPG_CF6_BIT  = 2;
    localparam logic [7:0] HPG_FLAGS_USED = 8'hCC;
    // Spreads one drive bit over each 4-bit nibble of ports 4 to 7.
    function automatic logic [31:0] hpg_nib_expand(input logic [7:0] m);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = {4{m[i]}};
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// file: logic/hpg_pad_if.sv
// Interface between the port register logic and the pad driver logic.
// Assumes one set of signals per group of pins of width W.
`timescale 1ns/1ps
`default_nettype none
interface hpg_pad_if #(parameter int W = 8);
    logic [W-1:0] lat;
    logic [W-1:0] push_pull;
    logic [W-1:0] ovr;
    logic [W-1:0] ovr_val;
    logic [W-1:0] hiz;
    logic         pu_dis;
    logic [W-1:0] out;
    logic [W-1:0] oe;
    logic [W-1:0] pu;
    modport ctl (output lat, push_pull, ovr, ovr_val, hiz, pu_dis,
                 input  out, oe, pu);
    modport drv (input  lat, push_pull, ovr, ovr_val, hiz, pu_dis,
                 output out, oe, pu);
endinterface
`default_nettype wire

// file: logic/hpg_pad_drv.sv
// Pad driver: turns latch, drive mode and memory-interface override into
// pin level, output enable and weak pull-up enable. Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module hpg_pad_drv (
    hpg_pad_if.drv pad
);
    // The override replaces the latch value only; drive mode stays.
    assign pad.out = (pad.ovr & pad.ovr_val) | (~pad.ovr & pad.lat);
    // Push-pull drives both levels, open-drain only the low level.
    assign pad.oe  = ~pad.hiz & (pad.push_pull | ~pad.out);
    // A pin driven low never fights its own pull-up.
    assign pad.pu  = {$bits(pad.pu){~pad.pu_dis}} & ~(pad.oe & ~pad.out);
endmodule
`default_nettype wire

// file: logic/hpg_pin_sync.sv
// Pin input synchroniser: three flip-flops and a level register; a new level is accepted once
// the second and third stages agree. Pins idle high under the pull-ups.
`timescale 1ns/1ps
`default_nettype none
module hpg_pin_sync #(
    parameter int W = 40
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output var  logic [W-1:0] lvl_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    wire  [W-1:0] agree = ~(s2_q ^ s3_q);

    // Stage one is read only by stage two, to contain metastability.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            lvl_q <= '1;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (agree & s3_q) | (~agree & lvl_q);
        end
    end
    assign lvl_o = lvl_q;
endmodule
`default_nettype wire

// file: logic/hpg_gpio.sv
// Function
// - Port 3 drive bit: 0 open-drain, 1 push-pull; resets to zero.
// - Two-wire and mode-0 receive pins are always open-drain.
// - Detected edge on port 3 bit 7 sets sticky pending flag 7.
// - Detected edge on port 3 bit 6 sets sticky pending flag 6.
// - Edge select 7 in bit 3: 0 falling, 1 rising.
// - Edge select 6 in bit 2: 0 falling, 1 rising.
// - Flag register bits 5-4 and 1-0 read zero; resets to zero.
// - Port data reads return the synchronised pin level.
// - Read-modify-write reads return the data latch instead.
// - Ports 4 to 7 latches and inputs exist even without pins.
// - Push-pull pin follows the latch, driving both levels.
// - Open-drain pin drives low on 0 and floats on 1.
// - High-port drive bits select push-pull per nibble, bit 0 port 4 low.
// - Open-drain pin with latch 1 serves as a digital input.
// - Pull-ups on by default, all off while global disable is 1.
// - Pull-up is switched off on any pin driven low.
// - Memory interface sets high-port pin values during its move phase.
// - Memory read phase turns off data bus output drivers.
// - Ports 4 to 7 data latches reset to all ones, read and write.
//
// Top of the port 3 and ports 4 to 7 GPIO block with edge interrupts.
// Assumes a single-cycle register bus from the core and a pad ring that
// resolves pin level from output, output enable and pull-up enable.
`timescale 1ns/1ps
`default_nettype none
module hpg_gpio
    import hpg_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_rd_i,
    input  wire logic        sfr_rmw_i,
    output var  logic [7:0]  sfr_rdata_o,
    input  wire logic        pullup_global_disable_i,
    input  wire logic [7:0]  p3_od_force_i,
    input  wire logic        external_memory_iface_hi_i,
    input  wire logic        external_move_exec_i,
    input  wire logic        external_move_read_i,
    input  wire logic [31:0] external_memory_iface_sel_i,
    input  wire logic [31:0] external_memory_iface_dbus_i,
    input  wire logic [31:0] external_memory_iface_val_i,
    input  wire logic [7:0]  p3_pin_i,
    output var  logic [7:0]  p3_pin_o,
    output var  logic [7:0]  p3_pin_oe_o,
    output var  logic [7:0]  p3_pullup_o,
    input  wire logic [31:0] hp_pin_i,
    output var  logic [31:0] hp_pin_o,
    output var  logic [31:0] hp_pin_oe_o,
    output var  logic [31:0] hp_pullup_o,
    output var  logic        ext_irq7_pending_o,
    output var  logic        ext_irq6_pending_o
);
    // Software-visible state.
    logic [7:0]  p3_lat_q;
    logic [7:0]  port3_drive_select_q;
    logic [7:0]  high_ports_nibble_drive_select_q;
    logic [31:0] hp_lat_q;
    logic        ext_irq7_pending_q;
    logic        ext_irq6_pending_q;
    logic        ext_irq7_edge_select_q;
    logic        ext_irq6_edge_select_q;
    logic [1:0]  irq_lvl_prev_q;
    logic [7:0]  rdata_q;
    logic [39:0] pin_lvl;

    // Register decode.
    wire wr_p3    = sfr_wr_i && (sfr_addr_i == HPG_P3_DATA_ADDR);
    wire wr_p3m   = sfr_wr_i && (sfr_addr_i == HPG_P3_DRIVE_ADDR);
    wire wr_flags = sfr_wr_i && (sfr_addr_i == HPG_P3_FLAGS_ADDR);
    wire wr_hpm   = sfr_wr_i && (sfr_addr_i == HPG_HP_DRIVE_ADDR);
    wire [3:0] wr_hp = {sfr_wr_i && (sfr_addr_i == HPG_P7_DATA_ADDR),
                        sfr_wr_i && (sfr_addr_i == HPG_P6_DATA_ADDR),
                        sfr_wr_i && (sfr_addr_i == HPG_P5_DATA_ADDR),
                        sfr_wr_i && (sfr_addr_i == HPG_P4_DATA_ADDR)};

    // Pin inputs of all forty pins pass the synchroniser.
    hpg_pin_sync #(
        .W (40)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     ({hp_pin_i, p3_pin_i}),
        .lvl_o     (pin_lvl)
    );

    wire [7:0]  p3_lvl = pin_lvl[7:0];
    wire [31:0] hp_lvl = pin_lvl[39:8];

    // Edge detection compares consecutive accepted levels of bits 7 and 6.
    wire lvl7 = p3_lvl[7];
    wire lvl6 = p3_lvl[6];
    wire edge7 = ext_irq7_edge_select_q ? (lvl7 & ~irq_lvl_prev_q[1])
                                        : (~lvl7 & irq_lvl_prev_q[1]);
    wire edge6 = ext_irq6_edge_select_q ? (lvl6 & ~irq_lvl_prev_q[0])
                                        : (~lvl6 & irq_lvl_prev_q[0]);

    // Flags: a write stores the bit, but a same-cycle edge wins over a clear.
    wire flag7_d = (wr_flags ? sfr_wdata_i[HPG_IRQ7_BIT]
                             : ext_irq7_pending_q) | edge7;
    wire flag6_d = (wr_flags ? sfr_wdata_i[HPG_IRQ6_BIT]
                             : ext_irq6_pending_q) | edge6;

    // Unused flag bits are not stored, so they always read as zero.
    wire [7:0] flags_rd = {ext_irq7_pending_q, ext_irq6_pending_q, 2'b00,
                           ext_irq7_edge_select_q, ext_irq6_edge_select_q,
                           2'b00};

    // Port data reads see the pins, except on a read-modify-write read.
    wire [7:0] p3_rd = sfr_rmw_i ? p3_lat_q : p3_lvl;
    wire [31:0] hp_rd = sfr_rmw_i ? hp_lat_q : hp_lvl;

    // Read data selection; unmapped offsets answer zero.
    logic [7:0] rd_mux;
    always_comb begin
        case (sfr_addr_i)
            HPG_P3_DATA_ADDR:  rd_mux = p3_rd;
            HPG_P3_DRIVE_ADDR: rd_mux = port3_drive_select_q;
            HPG_P3_FLAGS_ADDR: rd_mux = flags_rd;
            HPG_HP_DRIVE_ADDR: rd_mux = high_ports_nibble_drive_select_q;
            HPG_P4_DATA_ADDR:  rd_mux = hp_rd[7:0];
            HPG_P5_DATA_ADDR:  rd_mux = hp_rd[15:8];
            HPG_P6_DATA_ADDR:  rd_mux = hp_rd[23:16];
            HPG_P7_DATA_ADDR:  rd_mux = hp_rd[31:24];
            default:           rd_mux = 8'h00;
        endcase
    end

    // Port latches and drive-select registers.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            p3_lat_q                         <= HPG_LATCH_RST;
            port3_drive_select_q             <= HPG_DRIVE_RST;
            high_ports_nibble_drive_select_q <= HPG_DRIVE_RST;
            hp_lat_q                         <= {4{HPG_LATCH_RST}};
        end else begin
            if (wr_p3) p3_lat_q <= sfr_wdata_i;
            if (wr_p3m) port3_drive_select_q <= sfr_wdata_i;
            if (wr_hpm) high_ports_nibble_drive_select_q <= sfr_wdata_i;
            for (int i = 0; i < 4; i++) begin
                if (wr_hp[i]) hp_lat_q[i*8 +: 8] <= sfr_wdata_i;
            end
        end
    end

    // Edge flag register and the previous levels used for edge detection.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ext_irq7_pending_q     <= HPG_FLAGS_RST[HPG_IRQ7_BIT];
            ext_irq6_pending_q     <= HPG_FLAGS_RST[HPG_IRQ6_BIT];
            ext_irq7_edge_select_q <= HPG_FLAGS_RST[HPG_CF7_BIT];
            ext_irq6_edge_select_q <= HPG_FLAGS_RST[HPG_CF6_BIT];
            irq_lvl_prev_q         <= 2'b11;
        end else begin
            ext_irq7_pending_q <= flag7_d;
            ext_irq6_pending_q <= flag6_d;
            if (wr_flags) begin
                ext_irq7_edge_select_q <= sfr_wdata_i[HPG_CF7_BIT];
                ext_irq6_edge_select_q <= sfr_wdata_i[HPG_CF6_BIT];
            end
            irq_lvl_prev_q <= {lvl7, lvl6};
        end
    end

    // Read data is captured on the read strobe and held until the next one.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd_i) begin
            rdata_q <= rd_mux;
        end
    end

    // Port 3 pads: forced open-drain pins ignore their drive-select bit.
    hpg_pad_if #(.W(8))  p3_pad ();
    assign p3_pad.lat       = p3_lat_q;
    assign p3_pad.push_pull = port3_drive_select_q & ~p3_od_force_i;
    assign p3_pad.ovr       = 8'h00;
    assign p3_pad.ovr_val   = 8'h00;
    assign p3_pad.hiz       = 8'h00;
    assign p3_pad.pu_dis    = pullup_global_disable_i;
    hpg_pad_drv u_p3_drv (
        .pad (p3_pad.drv)
    );

    // High-port pads: the memory interface takes over selected pins during
    // the move phase; its reads float the data bus pins. Drive mode holds.
    wire external_memory_iface_act  = external_memory_iface_hi_i & external_move_exec_i;
    wire [31:0] external_memory_iface_ovr = {32{external_memory_iface_act}} & external_memory_iface_sel_i;
    wire [31:0] external_memory_iface_hiz = {32{external_memory_iface_act & external_move_read_i}}
                           & external_memory_iface_dbus_i;
    hpg_pad_if #(.W(32)) hp_pad ();
    assign hp_pad.lat       = hp_lat_q;
    assign hp_pad.push_pull =
        hpg_nib_expand(high_ports_nibble_drive_select_q);
    assign hp_pad.ovr       = external_memory_iface_ovr;
    assign hp_pad.ovr_val   = external_memory_iface_val_i;
    assign hp_pad.hiz       = external_memory_iface_hiz;
    assign hp_pad.pu_dis    = pullup_global_disable_i;
    hpg_pad_drv u_hp_drv (
        .pad (hp_pad.drv)
    );

    // Outputs.
    assign sfr_rdata_o        = rdata_q;
    assign p3_pin_o           = p3_pad.out;
    assign p3_pin_oe_o        = p3_pad.oe;
    assign p3_pullup_o        = p3_pad.pu;
    assign hp_pin_o           = hp_pad.out;
    assign hp_pin_oe_o        = hp_pad.oe;
    assign hp_pullup_o        = hp_pad.pu;
    assign ext_irq7_pending_o = ext_irq7_pending_q;
    assign ext_irq6_pending_o = ext_irq6_pending_q;

    // Checks on the block's own outputs and state.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_od_force;
        p3_od_force_i[0] && p3_lat_q[0] |-> !p3_pin_oe_o[0];
    endproperty
    a_od_force: assert property (p_od_force)
        else $error("forced open-drain pin is driving high");

    property p_irq7_rise;
        $rose(lvl7) && ext_irq7_edge_select_q |=> ext_irq7_pending_o;
    endproperty
    a_irq7_rise: assert property (p_irq7_rise)
        else $error("rising edge on bit 7 did not set flag 7");

    property p_irq6_fall;
        $fell(lvl6) && !ext_irq6_edge_select_q |=> ext_irq6_pending_o;
    endproperty
    a_irq6_fall: assert property (p_irq6_fall)
        else $error("falling edge on bit 6 did not set flag 6");

    property p_irq7_wrong_edge;
        $fell(lvl7) && ext_irq7_edge_select_q && !ext_irq7_pending_o
            && !wr_flags |=> !ext_irq7_pending_o;
    endproperty
    a_irq7_wrong_edge: assert property (p_irq7_wrong_edge)
        else $error("flag 7 set by the unselected edge");

    property p_irq6_wrong_edge;
        $rose(lvl6) && !ext_irq6_edge_select_q && !ext_irq6_pending_o
            && !wr_flags |=> !ext_irq6_pending_o;
    endproperty
    a_irq6_wrong_edge: assert property (p_irq6_wrong_edge)
        else $error("flag 6 set by the unselected edge");

    property p_flags_unused;
        sfr_rd_i && sfr_addr_i == HPG_P3_FLAGS_ADDR
            |=> (sfr_rdata_o & ~HPG_FLAGS_USED) == 8'h00;
    endproperty
    a_flags_unused: assert property (p_flags_unused)
        else $error("unused flag bits read non-zero");

    property p_pin_read;
        sfr_rd_i && !sfr_rmw_i && sfr_addr_i == HPG_P4_DATA_ADDR
            |=> sfr_rdata_o == $past(hp_lvl[7:0]);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("port 4 read did not return pin levels");

    property p_rmw_read;
        sfr_rd_i && sfr_rmw_i && sfr_addr_i == HPG_P4_DATA_ADDR
            |=> sfr_rdata_o == $past(hp_lat_q[7:0]);
    endproperty
    a_rmw_read: assert property (p_rmw_read)
        else $error("modify read of port 4 did not return latch");

    property p_pp_low;
        port3_drive_select_q[0] && !p3_od_force_i[0] && !p3_lat_q[0]
            |-> p3_pin_oe_o[0] && !p3_pin_o[0] && !p3_pullup_o[0];
    endproperty
    a_pp_low: assert property (p_pp_low)
        else $error("low push-pull pin not driven or pull-up on");

    property p_od_high;
        !high_ports_nibble_drive_select_q[7] && hp_lat_q[31] && !external_memory_iface_act
            |-> !hp_pin_oe_o[31];
    endproperty
    a_od_high: assert property (p_od_high)
        else $error("open-drain high pin is being driven");

    property p_external_memory_iface_read;
        external_memory_iface_act && external_move_read_i && external_memory_iface_dbus_i[0]
            |-> !hp_pin_oe_o[0];
    endproperty
    a_external_memory_iface_read: assert property (p_external_memory_iface_read)
        else $error("data bus pin driven during memory read");

    c_irq7: cover property (edge7 ##1 ext_irq7_pending_o);
    c_clear_race: cover property (wr_flags && edge6);
    c_external_memory_iface: cover property (external_memory_iface_act && external_move_read_i);
    c_rmw: cover property (sfr_rd_i && sfr_rmw_i);
endmodule
`default_nettype wire

// file: bench/hpg_board.sv
// Board model for the port pins: resolves each pin from the block's drive,
// an external driver owned by the bench, and the weak pull-up.
// Assumes bit 0 to 7 are port 3 and bits 8 to 39 are ports 4 to 7.
`timescale 1ns/1ps
`default_nettype none
module hpg_board (
    input  wire logic        ref_clk_i,
    input  wire logic [39:0] out_i,
    input  wire logic [39:0] oe_i,
    input  wire logic [39:0] pu_i,
    input  wire logic [39:0] ext_en_i,
    input  wire logic [39:0] ext_val_i,
    output var  logic [39:0] pin_o
);
    // A floating pin shows a pattern that flips every cycle, so that a
    // design relying on an undriven level cannot pass by luck.
    logic [39:0] noise_q = 40'hAA_AAAA_AAAA;

    // The noise pattern toggles on every rising clock edge.
    always_ff @(posedge ref_clk_i) begin
        noise_q <= ~noise_q;
    end

    // Block drive wins; an external driver sets a released pin.
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else if (pu_i[i]) begin
                pin_o[i] = 1'b1;
            end else begin
                pin_o[i] = noise_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the port 3 and ports 4 to 7 GPIO block.
// Assumes the board model resolves all 40 pins around the block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hpg_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [7:0]  wdata     = 8'h00;
    logic        wr_en     = 1'b0;
    logic        rd_en     = 1'b0;
    logic        rmw       = 1'b0;
    logic        pud       = 1'b0;
    logic [7:0]  od_force  = 8'h00;
    logic        emi_hi    = 1'b0;
    logic        mv_exec   = 1'b0;
    logic        mv_read   = 1'b0;
    logic [31:0] emi_sel   = 32'h0000_0000;
    logic [31:0] emi_dbus  = 32'h0000_0000;
    logic [31:0] emi_val   = 32'h0000_0000;
    logic [39:0] ext_en    = 40'h00_0000_0000;
    logic [39:0] ext_val   = 40'h00_0000_0000;
    logic [7:0]  rdata;
    logic [7:0]  p3_out, p3_oe, p3_pu;
    logic [31:0] hp_out, hp_oe, hp_pu;
    logic        irq7, irq6;
    logic [39:0] pins;
    logic [7:0]  d;
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;

    hpg_gpio hpg_gpio_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr_en), .sfr_wdata_i(wdata), .sfr_rd_i(rd_en),
        .sfr_rmw_i(rmw), .sfr_rdata_o(rdata),
        .pullup_global_disable_i(pud), .p3_od_force_i(od_force),
        .external_memory_iface_hi_i(emi_hi),
        .external_move_exec_i(mv_exec), .external_move_read_i(mv_read),
        .external_memory_iface_sel_i(emi_sel),
        .external_memory_iface_dbus_i(emi_dbus),
        .external_memory_iface_val_i(emi_val),
        .p3_pin_i(pins[7:0]), .p3_pin_o(p3_out), .p3_pin_oe_o(p3_oe),
        .p3_pullup_o(p3_pu), .hp_pin_i(pins[39:8]), .hp_pin_o(hp_out),
        .hp_pin_oe_o(hp_oe), .hp_pullup_o(hp_pu),
        .ext_irq7_pending_o(irq7), .ext_irq6_pending_o(irq6));

    hpg_board hpg_board_inst (
        .ref_clk_i(ref_clk_i), .out_i({hp_out, p3_out}),
        .oe_i({hp_oe, p3_oe}), .pu_i({hp_pu, p3_pu}),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pins));

    // The clock toggles every 12.5 ns, a half period of the 25 ns clock period.
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // A hang is cut short far beyond the hundred or so cycles needed.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // The strobe drops one edge after it rose, so writes never overlap.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk_i);
        wr_en <= 1'b0;
    endtask

    // Read data is registered, so it is taken in the following half cycle.
    task automatic rd(input logic [7:0] a, input logic m,
                      output logic [7:0] v);
        @(posedge ref_clk_i);
        addr  <= a;
        rd_en <= 1'b1;
        rmw   <= m;
        @(posedge ref_clk_i);
        rd_en <= 1'b0;
        rmw   <= 1'b0;
        @(negedge ref_clk_i);
        v = rdata;
    endtask

    task automatic t_reset();
        rd(HPG_P3_DRIVE_ADDR, 1'b0, d); chk("p3 drive", d, 8'h00);
        rd(HPG_P3_FLAGS_ADDR, 1'b0, d); chk("flags", d, 8'h00);
        rd(HPG_HP_DRIVE_ADDR, 1'b0, d); chk("hp drive", d, 8'h00);
        rd(HPG_P4_DATA_ADDR, 1'b1, d); chk("p4 latch", d, 8'hFF);
        rd(HPG_P7_DATA_ADDR, 1'b0, d); chk("p7 pins", d, 8'hFF);
        rd(8'h3C, 1'b0, d); chk("unmapped", d, 8'h00);
        rd(HPG_P5_DATA_ADDR, 1'b0, d); chk("p5 pins", d, 8'hFF);
        rd(HPG_P3_DATA_ADDR, 1'b1, d); chk("p3 latch", d, 8'hFF);
        chk("p3 oe", p3_oe, 8'h00);
        chk("p3 pullup", p3_pu, 8'hFF);
        chk("hp pullup", hp_pu, 32'hFFFF_FFFF);
        $display("t_reset done");
    endtask

    task automatic t_p3_drive();
        wr(HPG_P3_DRIVE_ADDR, 8'h01);
        wr(HPG_P3_DATA_ADDR, 8'hFE);
        @(negedge ref_clk_i);
        chk("p3 pp low oe", p3_oe[0], 1'b1);
        chk("p3 pp low out", p3_out[0], 1'b0);
        chk("p3 low pullup", p3_pu[0], 1'b0);
        chk("p3 od high oe", p3_oe[1], 1'b0);
        // Let the driven low level pass the synchroniser before reading.
        repeat (3) @(posedge ref_clk_i);
        rd(HPG_P3_DATA_ADDR, 1'b0, d); chk("p3 pins", d, 8'hFE);
        wr(HPG_P3_DATA_ADDR, 8'hFF);
        @(negedge ref_clk_i);
        chk("p3 pp high", {p3_oe[0], p3_out[0]}, 2'b11);
        @(posedge ref_clk_i);
        od_force <= 8'h01;
        @(negedge ref_clk_i);
        chk("p3 forced od", p3_oe[0], 1'b0);
        @(posedge ref_clk_i);
        od_force <= 8'h00;
        $display("t_p3_drive done");
    endtask

    task automatic t_high_ports();
        wr(HPG_HP_DRIVE_ADDR, 8'h81);
        wr(HPG_P4_DATA_ADDR, 8'h5A);
        @(posedge ref_clk_i);
        ext_en  <= 40'h00_0000_4000;
        ext_val <= 40'h00_0000_0000;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("p4 oe", hp_oe[7:0], 8'hAF);
        chk("p4 out", hp_out[3:0], 4'hA);
        chk("p7 high oe", hp_oe[31:28], 4'hF);
        chk("p4 pullup", hp_pu[7:0], 8'h5A);
        rd(HPG_P4_DATA_ADDR, 1'b0, d); chk("p4 pins", d, 8'h1A);
        rd(HPG_P4_DATA_ADDR, 1'b1, d); chk("p4 rmw", d, 8'h5A);
        wr(HPG_P6_DATA_ADDR, 8'h00);
        rd(HPG_P6_DATA_ADDR, 1'b1, d); chk("p6 latch", d, 8'h00);
        @(posedge ref_clk_i);
        ext_en <= 40'h00_0000_0000;
        $display("t_high_ports done");
    endtask

    task automatic t_edges();
        wr(HPG_P3_FLAGS_ADDR, 8'h08);
        @(posedge ref_clk_i);
        ext_en <= 40'h00_0000_00C0;
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("fall on 7", irq7, 1'b0);
        chk("fall on 6", irq6, 1'b1);
        repeat (20) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("6 sticky", irq6, 1'b1);
        wr(HPG_P3_FLAGS_ADDR, 8'h08);
        @(posedge ref_clk_i);
        ext_en <= 40'h00_0000_0000;
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("rise on 7", irq7, 1'b1);
        chk("rise on 6", irq6, 1'b0);
        rd(HPG_P3_FLAGS_ADDR, 1'b0, d); chk("flags 7", d, 8'h88);
        wr(HPG_P3_FLAGS_ADDR, 8'hFF);
        rd(HPG_P3_FLAGS_ADDR, 1'b0, d); chk("flags all", d, 8'hCC);
        wr(HPG_P3_FLAGS_ADDR, 8'h00);
        rd(HPG_P3_FLAGS_ADDR, 1'b0, d); chk("cleared", d, 8'h00);
        $display("t_edges done");
    endtask

    task automatic t_memiface();
        // Software has cleared the low-port select before using high ports.
        @(posedge ref_clk_i);
        emi_hi   <= 1'b1;
        mv_exec  <= 1'b1;
        emi_sel  <= 32'h0000_00FF;
        emi_val  <= 32'h0000_00C3;
        emi_dbus <= 32'h0000_00FF;
        @(negedge ref_clk_i);
        chk("emi out", hp_out[3:0], 4'h3);
        chk("emi oe", hp_oe[7:0], 8'h3F);
        @(posedge ref_clk_i);
        mv_read <= 1'b1;
        @(negedge ref_clk_i);
        chk("emi read oe", hp_oe[7:0], 8'h00);
        @(posedge ref_clk_i);
        mv_exec <= 1'b0;
        mv_read <= 1'b0;
        emi_hi  <= 1'b0;
        @(negedge ref_clk_i);
        chk("latch back", hp_out[3:0], 4'hA);
        $display("t_memiface done");
    endtask

    // Run last: with pull-ups off the floating pins toggle freely.
    task automatic t_pullup_off();
        @(posedge ref_clk_i);
        pud <= 1'b1;
        @(negedge ref_clk_i);
        chk("p3 pu off", p3_pu, 8'h00);
        chk("hp pu off", hp_pu, 32'h0000_0000);
        $display("t_pullup_off done");
    endtask

    // Reset is held for five cycles, then the scenarios run in turn.
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_p3_drive();
        t_high_ports();
        t_edges();
        t_memiface();
        t_pullup_off();
        finish_test();
    end
endmodule
`default_nettype wire
